// >>> hdl/uart_tx_abd_pkg.sv
// constants for the nine-bit transmitter with baud detection
// assumes an 8-bit register port with a 4-bit word address
package uart_tx_abd_pkg;

   // register word offsets
   localparam logic [3:0] OFS_TX_CTRL   = 4'h0;
   localparam logic [3:0] OFS_TX_DATA   = 4'h1;
   localparam logic [3:0] OFS_RX_DATA   = 4'h2;
   localparam logic [3:0] OFS_DIV_LOW   = 4'h3;
   localparam logic [3:0] OFS_DIV_HIGH  = 4'h4;
   localparam logic [3:0] OFS_BAUD_CTRL = 4'h5;
   localparam logic [3:0] OFS_INT_CTRL  = 4'h6;

   // tx_control_status fields
   localparam int B_NINTH  = 0;
   localparam int B_EMPTY  = 1;
   localparam int B_HSPEED = 2;
   localparam int B_CLKMOD = 3;
   localparam int B_TRANSMIT_ENABLE   = 4;
   localparam int B_NINE   = 5;
   localparam int B_INVERT = 6;
   localparam int B_PORTEN = 7;

   // baud_control fields
   localparam int B_ABD    = 0;
   localparam int B_WAKE   = 1;
   localparam int B_WIDE   = 3;

   // interrupt_control fields
   localparam int B_TX_INT_FLAG   = 0;
   localparam int B_RXIF   = 1;
   localparam int B_TX_INT_ENABLE   = 2;
   localparam int B_PERIPHERAL_INT_GATE   = 3;
   localparam int B_GIE    = 4;

   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [15:0] ABD_FIRST = 16'h0001;
   localparam logic [2:0] ABD_LAST_EDGE = 3'h4;

   // prescaler masks: base clock /64 /16 /4, detect clock eight times slower
   localparam logic [8:0] MASK_BASE_SLOW = 9'h03f;
   localparam logic [8:0] MASK_BASE_MID  = 9'h00f;
   localparam logic [8:0] MASK_BASE_FAST = 9'h003;
   localparam logic [8:0] MASK_ABD_SLOW  = 9'h1ff;
   localparam logic [8:0] MASK_ABD_MID   = 9'h07f;
   localparam logic [8:0] MASK_ABD_FAST  = 9'h01f;

   localparam logic [3:0] FRAME_BITS_8 = 4'ha;
   localparam logic [3:0] FRAME_BITS_9 = 4'hb;

   typedef enum logic [2:0] {
      st_idle       = 3'b000,
      st_break_low  = 3'b001,
      st_break_high = 3'b010,
      st_start      = 3'b011,
      st_edge1      = 3'b100,
      st_count      = 3'b101
   } abd_state_t;

endpackage : uart_tx_abd_pkg

// >>> hdl/bit_sync.sv
// two-stage synchroniser for one pin input
// assumes the pin is asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic pin_in,
   output logic      sync_out
);
   logic meta_r;

   // pin idles high, so reset to high
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_r   <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_r   <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule : bit_sync
`default_nettype wire

// >>> hdl/tx_shifter.sv
// frame shifter: start bit, 8 or 9 data bits lsb first, stop bit
// assumes bit_tick pulses once per bit period while busy
`timescale 1ns/1ps
`default_nettype none
module tx_shifter (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic [8:0] data9,
   input  wire logic       nine,
   input  wire logic       bit_tick,
   output logic            line,
   output logic            busy
);
   logic [10:0] sh_r;
   logic [3:0]  left_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sh_r   <= '1;
         left_r <= 4'h0;
      end else if (load) begin
         sh_r   <= {1'b1, nine ? data9[8] : 1'b1, data9[7:0], 1'b0};
         left_r <= nine ? uart_tx_abd_pkg::FRAME_BITS_9 : uart_tx_abd_pkg::FRAME_BITS_8;
      end else if (bit_tick && busy) begin
         sh_r   <= {1'b1, sh_r[10:1]};
         left_r <= left_r - 4'h1;
      end
   end

   assign busy = (left_r != 4'h0);
   assign line = busy ? sh_r[0] : 1'b1;

   chk_frame_start: assert property (@(posedge core_clk) disable iff (rst)
      load |=> (line == 1'b0) && busy)
      else $error("start bit not low after load");
endmodule : tx_shifter
`default_nettype wire

// >>> hdl/uart_tx_abd.sv
// nine-bit serial transmitter with automatic baud detection
// assumes a plain 8-bit register port and an asynchronous rx pin
`timescale 1ns/1ps
`default_nettype none
module uart_tx_abd (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       rx_pin,
   output logic            tx_pin,
   output logic            irq_req
);

   logic [7:0]  ctl_r;
   logic [7:0]  baud_ctl_r;
   logic [7:0]  int_ctl_r;
   logic [7:0]  div_low_r;
   logic [7:0]  div_high_r;
   logic [8:0]  hold_r;
   logic        hold_full_r;
   logic        rx_flag_r;
   logic [8:0]  psc_r;
   logic [15:0] brg_cnt_r;
   logic [2:0]  edge_r;
   logic        rx_d_r;
   logic        rx_s;
   logic        rx_rise;
   logic        rx_fall;
   logic        wr_ctl;
   logic        wr_data;
   logic        wr_low;
   logic        wr_high;
   logic        wr_baud;
   logic        wr_int;
   logic        rd_rx;
   logic        port_on;
   logic        tx_on;
   logic        abd_on;
   logic        tx_flag;
   logic        load;
   logic        busy;
   logic        line;
   logic        base_tick;
   logic        abd_tick;
   logic        bit_tick;
   logic        abd_done;
   logic [8:0]  base_mask;
   logic [8:0]  abd_mask;
   logic [15:0] div_eff;
   uart_tx_abd_pkg::abd_state_t st_r;
   uart_tx_abd_pkg::abd_state_t st_nxt;

   assign wr_ctl  = reg_wr && (reg_addr == uart_tx_abd_pkg::OFS_TX_CTRL);
   assign wr_data = reg_wr && (reg_addr == uart_tx_abd_pkg::OFS_TX_DATA);
   assign wr_low  = reg_wr && (reg_addr == uart_tx_abd_pkg::OFS_DIV_LOW);
   assign wr_high = reg_wr && (reg_addr == uart_tx_abd_pkg::OFS_DIV_HIGH);
   assign wr_baud = reg_wr && (reg_addr == uart_tx_abd_pkg::OFS_BAUD_CTRL);
   assign wr_int  = reg_wr && (reg_addr == uart_tx_abd_pkg::OFS_INT_CTRL);
   assign rd_rx   = reg_rd && (reg_addr == uart_tx_abd_pkg::OFS_RX_DATA);

   // asynchronous operation needs port on, clocked mode off
   assign port_on = ctl_r[uart_tx_abd_pkg::B_PORTEN] && !ctl_r[uart_tx_abd_pkg::B_CLKMOD];
   assign tx_on   = port_on && ctl_r[uart_tx_abd_pkg::B_TRANSMIT_ENABLE];
   assign abd_on  = (st_r != uart_tx_abd_pkg::st_idle);

   // rx pin resynchronised before any use
   bit_sync u_rx_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   (rx_pin),
      .sync_out (rx_s)
   );

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_d_r <= 1'b1;
      end else begin
         rx_d_r <= rx_s;
      end
   end

   assign rx_rise = rx_s && !rx_d_r;
   assign rx_fall = !rx_s && rx_d_r;

   // control and interrupt enable registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctl_r     <= uart_tx_abd_pkg::RST_REG8;
         int_ctl_r <= uart_tx_abd_pkg::RST_REG8;
      end else begin
         if (wr_ctl) begin
            ctl_r <= reg_wdata;
         end
         if (wr_int) begin
            int_ctl_r <= reg_wdata;
         end
      end
   end

   // baud_control: hardware clears the detect enable on completion
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         baud_ctl_r <= uart_tx_abd_pkg::RST_REG8;
      end else if (wr_baud) begin
         baud_ctl_r <= reg_wdata;
      end else if (abd_done) begin
         baud_ctl_r[uart_tx_abd_pkg::B_ABD] <= 1'b0;
      end
   end

   // prescaler; detect masks are three bits longer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         psc_r <= 9'h000;
      end else begin
         psc_r <= psc_r + 9'h001;
      end
   end

   // detect clock one eighth of base clock
   always_comb begin
      unique case ({baud_ctl_r[uart_tx_abd_pkg::B_WIDE], ctl_r[uart_tx_abd_pkg::B_HSPEED]})
         2'b00: begin
            base_mask = uart_tx_abd_pkg::MASK_BASE_SLOW;
            abd_mask  = uart_tx_abd_pkg::MASK_ABD_SLOW;
         end
         2'b11: begin
            base_mask = uart_tx_abd_pkg::MASK_BASE_FAST;
            abd_mask  = uart_tx_abd_pkg::MASK_ABD_FAST;
         end
         default: begin
            base_mask = uart_tx_abd_pkg::MASK_BASE_MID;
            abd_mask  = uart_tx_abd_pkg::MASK_ABD_MID;
         end
      endcase
   end

   assign base_tick = ((psc_r & base_mask) == base_mask);
   assign abd_tick  = ((psc_r & abd_mask) == abd_mask);

   assign div_eff = baud_ctl_r[uart_tx_abd_pkg::B_WIDE] ? {div_high_r, div_low_r}
                                                      : {8'h00, div_low_r};

   // bit timer reloads while idle so the start bit gets a full period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         brg_cnt_r <= 16'h0000;
      end else if (!busy || load) begin
         brg_cnt_r <= div_eff;
      end else if (base_tick) begin
         brg_cnt_r <= (brg_cnt_r == 16'h0000) ? div_eff : brg_cnt_r - 16'h0001;
      end
   end

   assign bit_tick = busy && base_tick && (brg_cnt_r == 16'h0000);

   // detection sequencer
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         uart_tx_abd_pkg::st_idle: begin
            if (baud_ctl_r[uart_tx_abd_pkg::B_ABD] && port_on) begin
               st_nxt = baud_ctl_r[uart_tx_abd_pkg::B_WAKE] ? uart_tx_abd_pkg::st_break_low
                                                            : uart_tx_abd_pkg::st_start;
            end
         end
         uart_tx_abd_pkg::st_break_low: begin
            if (!rx_s) st_nxt = uart_tx_abd_pkg::st_break_high;
         end
         uart_tx_abd_pkg::st_break_high: begin
            if (rx_rise) st_nxt = uart_tx_abd_pkg::st_start;
         end
         uart_tx_abd_pkg::st_start: begin
            if (rx_fall) st_nxt = uart_tx_abd_pkg::st_edge1;
         end
         uart_tx_abd_pkg::st_edge1: begin
            if (rx_rise) st_nxt = uart_tx_abd_pkg::st_count;
         end
         uart_tx_abd_pkg::st_count: begin
            if (abd_done) st_nxt = uart_tx_abd_pkg::st_idle;
         end
         default: st_nxt = uart_tx_abd_pkg::st_idle;
      endcase
      // software abort drops the sequence
      if (!baud_ctl_r[uart_tx_abd_pkg::B_ABD]) begin
         st_nxt = uart_tx_abd_pkg::st_idle;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= uart_tx_abd_pkg::st_idle;
      end else begin
         st_r <= st_nxt;
      end
   end

   // fifth rising edge ends the measurement
   assign abd_done = (st_r == uart_tx_abd_pkg::st_count) && rx_rise
                     && (edge_r == uart_tx_abd_pkg::ABD_LAST_EDGE)
                     && baud_ctl_r[uart_tx_abd_pkg::B_ABD];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         edge_r <= 3'h0;
      end else if (st_r == uart_tx_abd_pkg::st_edge1) begin
         edge_r <= 3'h1;
      end else if ((st_r == uart_tx_abd_pkg::st_count) && rx_rise) begin
         edge_r <= edge_r + 3'h1;
      end
   end

   // divisor pair: software writes, counter while detecting
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_low_r  <= uart_tx_abd_pkg::RST_REG8;
         div_high_r <= uart_tx_abd_pkg::RST_REG8;
      end else if ((st_r == uart_tx_abd_pkg::st_edge1) && rx_rise) begin
         {div_high_r, div_low_r} <= uart_tx_abd_pkg::ABD_FIRST;
      end else if ((st_r == uart_tx_abd_pkg::st_count) && abd_tick && !abd_done) begin
         // full 16-bit count whatever the width select
         {div_high_r, div_low_r} <= {div_high_r, div_low_r} + 16'h0001;
      end else begin
         if (wr_low) div_low_r <= reg_wdata;
         if (wr_high) div_high_r <= reg_wdata;
      end
   end

   // receive flag: set beats the clearing read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_flag_r <= 1'b0;
      end else if (abd_done) begin
         rx_flag_r <= 1'b1;
      end else if (rd_rx) begin
         rx_flag_r <= 1'b0;
      end
   end

   // holding register; writes while disabled are dropped
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_r      <= 9'h000;
         hold_full_r <= 1'b0;
      end else if (wr_data && tx_on) begin
         // ninth bit must already be in place
         hold_r      <= {ctl_r[uart_tx_abd_pkg::B_NINTH], reg_wdata};
         hold_full_r <= 1'b1;
      end else if (load || !tx_on) begin
         hold_full_r <= 1'b0;
      end
   end

   // move to shifter as soon as it is free and no baud detection is running
   assign load = hold_full_r && !busy && tx_on && !abd_on;

   // flag follows an empty holding register
   assign tx_flag = tx_on && !hold_full_r;

   // ninth bit carries the address mark
   tx_shifter u_shift (
      .core_clk (core_clk),
      .rst      (rst),
      .load     (load),
      .data9    (hold_r),
      .nine     (ctl_r[uart_tx_abd_pkg::B_NINE]),
      .bit_tick (bit_tick),
      .line     (line),
      .busy     (busy)
   );

   // outputs from flops; pin idles at the inverted level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_pin  <= 1'b1;
         irq_req <= 1'b0;
      end else begin
         tx_pin  <= line ^ ctl_r[uart_tx_abd_pkg::B_INVERT];
         irq_req <= tx_flag && int_ctl_r[uart_tx_abd_pkg::B_TX_INT_ENABLE]
                    && int_ctl_r[uart_tx_abd_pkg::B_PERIPHERAL_INT_GATE] && int_ctl_r[uart_tx_abd_pkg::B_GIE];
      end
   end

   // read port, data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            uart_tx_abd_pkg::OFS_TX_CTRL: begin
               reg_rdata <= {ctl_r[7:2], !busy, ctl_r[0]};
            end
            uart_tx_abd_pkg::OFS_DIV_LOW:   reg_rdata <= div_low_r;
            uart_tx_abd_pkg::OFS_DIV_HIGH:  reg_rdata <= div_high_r;
            uart_tx_abd_pkg::OFS_BAUD_CTRL: reg_rdata <= baud_ctl_r;
            uart_tx_abd_pkg::OFS_INT_CTRL: begin
               reg_rdata <= {int_ctl_r[7:2], rx_flag_r, tx_flag};
            end
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   chk_enable_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
      (wr_ctl && reg_wdata[uart_tx_abd_pkg::B_TRANSMIT_ENABLE] && reg_wdata[uart_tx_abd_pkg::B_PORTEN]
       && !reg_wdata[uart_tx_abd_pkg::B_CLKMOD] && !hold_full_r && !wr_data) |=> tx_flag)
      else $error("transmit flag not set by enable");

   chk_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
      (tx_flag && (int_ctl_r[4:2] == 3'b111)) |=> irq_req)
      else $error("interrupt request missing");

   chk_write_starts: assert property (@(posedge core_clk) disable iff (rst)
      (wr_data && tx_on && !abd_on && !busy) |=> ##1 busy)
      else $error("write did not start a frame");

   chk_abd_holds_tx: assert property (@(posedge core_clk) disable iff (rst)
      (abd_on && !busy) |=> !busy)
      else $error("transmitter loaded during detection");

   chk_abd_seed: assert property (@(posedge core_clk) disable iff (rst)
      ((st_r == uart_tx_abd_pkg::st_edge1) && rx_rise && baud_ctl_r[0])
      |=> ({div_high_r, div_low_r} == 16'h0001) && (st_r == uart_tx_abd_pkg::st_count))
      else $error("detect count not seeded with one");

   // counter steps as one 16-bit value
   chk_abd_step: assert property (@(posedge core_clk) disable iff (rst)
      ((st_r == uart_tx_abd_pkg::st_count) && abd_tick && !abd_done)
      |=> ({div_high_r, div_low_r} == $past({div_high_r, div_low_r}) + 16'h0001))
      else $error("detect counter did not advance");

   chk_abd_finish: assert property (@(posedge core_clk) disable iff (rst)
      abd_done |=> !baud_ctl_r[uart_tx_abd_pkg::B_ABD] && rx_flag_r && !abd_on)
      else $error("detect completion incomplete");

   chk_rx_clear: assert property (@(posedge core_clk) disable iff (rst)
      (rd_rx && !abd_done) |=> !rx_flag_r)
      else $error("receive flag not cleared by read");

   chk_shift_empty: assert property (@(posedge core_clk) disable iff (rst)
      load |=> busy ##1 (reg_rdata[uart_tx_abd_pkg::B_EMPTY] == 1'b0
                         || !$past(reg_rd && (reg_addr == uart_tx_abd_pkg::OFS_TX_CTRL))))
      else $error("shift-empty status wrong after load");

   chk_idle_invert: assert property (@(posedge core_clk) disable iff (rst)
      (!busy && ctl_r[uart_tx_abd_pkg::B_INVERT]) [*2] |-> (tx_pin == 1'b0))
      else $error("inverted idle level wrong");

endmodule : uart_tx_abd
`default_nettype wire

// >>> test/remote_node.sv
// remote serial node: decodes frames from tx_pin, sends sync characters on rx_pin
// assumes bit periods counted in core_clk cycles and a pulled-up receive line
`timescale 1ns/1ps
`default_nettype none
module remote_node #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic core_clk,
   input  wire logic tx_pin,
   input  wire logic invert,
   input  wire logic nine,
   output logic      rx_pin
);
   logic [9:0] got_q[$];
   logic [9:0] frame;

   initial rx_pin = 1'b1;

   task automatic send_sync(input int p);
      logic [9:0] bits;
      bits = {1'b1, 8'h55, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_pin <= bits[i];
         repeat (p) @(posedge core_clk);
      end
   endtask : send_sync

   // long low, then one idle bit, ahead of a sync character
   task automatic send_break(input int p);
      rx_pin <= 1'b0;
      repeat (11 * p) @(posedge core_clk);
      rx_pin <= 1'b1;
      repeat (p) @(posedge core_clk);
   endtask : send_break

   // start, lsb first, stop
   // sampled on the falling edge so registered pin changes never race
   initial forever begin
      @(negedge core_clk);
      if ((tx_pin ^ invert) === 1'b0) begin
         repeat (BIT_CLKS / 2) @(negedge core_clk);
         // a short low after a polarity change is not a start bit
         if ((tx_pin ^ invert) === 1'b0) begin
            frame = '0;
            repeat (BIT_CLKS / 2 + 6) @(negedge core_clk);
            for (int i = 0; i < 9; i++) begin
               if (i < 8 || nine) begin
                  frame[i] = tx_pin ^ invert;
                  repeat (BIT_CLKS) @(negedge core_clk);
               end
            end
            frame[9] = tx_pin ^ invert;
            got_q.push_back(frame);
         end
      end
   end
endmodule : remote_node
`default_nettype wire

// >>> test/test_uart_tx_abd.sv
// self-checking bench for the nine-bit transmitter with baud detection
// assumes remote_node on the serial pins and the package register map
`timescale 1ns/1ps
`default_nettype none
module test_uart_tx_abd;
   localparam int DIV      = 3;
   localparam int BIT_CLKS = (DIV + 1) * 4;
   localparam int SYNC_P   = 128;
   logic       core_clk, rst, reg_wr, reg_rd, rx_pin, tx_pin, irq_req;
   logic       invert, nine, ninth, inv_n;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_v, d, lo;
   logic [8:0] exp9;
   integer     seed;
   int         n_mismatch, n_compared, k, ab;
   int         addrs[8] = '{0, 1, 2, 3, 4, 5, 6, 15};

   uart_tx_abd i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .irq_req(irq_req));
   remote_node #(.BIT_CLKS(BIT_CLKS)) i_node (.core_clk(core_clk), .tx_pin(tx_pin),
      .invert(invert), .nine(nine), .rx_pin(rx_pin));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd

   function automatic logic [7:0] ctrl_val(input logic nb, inv, nth, en);
      logic [7:0] v;
      v = 8'h00;
      v[uart_tx_abd_pkg::B_PORTEN] = 1'b1;
      v[uart_tx_abd_pkg::B_HSPEED] = 1'b1;
      v[uart_tx_abd_pkg::B_TRANSMIT_ENABLE]   = en;
      v[uart_tx_abd_pkg::B_NINE]   = nb;
      v[uart_tx_abd_pkg::B_INVERT] = inv;
      v[uart_tx_abd_pkg::B_NINTH]  = nth;
      return v;
   endfunction : ctrl_val

   // count starts at one and steps once per detect tick over eight bit periods
   function automatic int abd_expect(input int p, input int tick);
      return 1 + (8 * p) / tick;
   endfunction : abd_expect

   task automatic tally_and_finish();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic timed_out();
      n_mismatch++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      tally_and_finish();
   endtask : timed_out

   initial begin
      seed = 32'h1b5b;
      rst = 1'b1;
      {reg_wr, reg_rd, invert, nine, ninth} = '0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      n_mismatch = 0;
      n_compared = 0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      // reset values, unmapped place reads zero
      foreach (addrs[i]) begin
         rd(4'(addrs[i]));
         check({8'h00, rd_v}, (addrs[i] == 0) ? 16'h0002 : 16'h0000);
      end
      wr(uart_tx_abd_pkg::OFS_DIV_LOW, 8'(DIV));
      wr(uart_tx_abd_pkg::OFS_DIV_HIGH, 8'h00);
      wr(uart_tx_abd_pkg::OFS_BAUD_CTRL, 8'h01 << uart_tx_abd_pkg::B_WIDE);
      wr(uart_tx_abd_pkg::OFS_TX_CTRL, ctrl_val(1'b0, 1'b0, 1'b0, 1'b0));
      rd(uart_tx_abd_pkg::OFS_INT_CTRL);
      check(16'(rd_v[uart_tx_abd_pkg::B_TX_INT_FLAG]), 16'h0000);
      wr(uart_tx_abd_pkg::OFS_TX_CTRL, ctrl_val(1'b0, 1'b0, 1'b0, 1'b1));
      rd(uart_tx_abd_pkg::OFS_INT_CTRL);
      check(16'(rd_v[uart_tx_abd_pkg::B_TX_INT_FLAG]), 16'h0001);
      for (int m = 0; m < 8; m++) begin
         wr(uart_tx_abd_pkg::OFS_INT_CTRL, 8'(m) << uart_tx_abd_pkg::B_TX_INT_ENABLE);
         repeat (2) @(posedge core_clk);
         check(16'(irq_req), (m == 7) ? 16'h0001 : 16'h0000);
      end
      for (int n = 0; n < 8; n++) begin
         d = 8'($random(seed));
         nine = (n < 2) ? 1'b1 : 1'($random(seed));
         ninth = (n < 2) ? (n == 0) : 1'($random(seed));
         inv_n = (n < 2) ? 1'b0 : 1'($random(seed));
         if (n == 0)
            d = 8'h00;
         exp9 = nine ? {ninth, d} : {1'b0, d};
         wr(uart_tx_abd_pkg::OFS_TX_CTRL, ctrl_val(nine, inv_n, ninth, 1'b1));
         // node takes the new polarity as the idle pin flips, so no false start
         @(posedge core_clk);
         invert <= inv_n;
         wr(uart_tx_abd_pkg::OFS_TX_DATA, d);
         rd(uart_tx_abd_pkg::OFS_TX_CTRL);
         check(16'(rd_v[uart_tx_abd_pkg::B_EMPTY]), 16'h0000);
         k = 0;
         while (i_node.got_q.size() == 0 && k < 400) begin
            @(posedge core_clk);
            k++;
         end
         if (i_node.got_q.size() == 0)
            timed_out();
         check(16'(i_node.got_q.pop_front()), {6'h00, 1'b1, exp9});
         repeat (BIT_CLKS * 2) @(posedge core_clk);
         check(16'(tx_pin), 16'(!invert));
         rd(uart_tx_abd_pkg::OFS_TX_CTRL);
         check(16'(rd_v[uart_tx_abd_pkg::B_EMPTY]), 16'h0001);
      end
      // detect ticks of 32, 128 and 512 clocks; wake on the second pass
      for (int j = 0; j < 3; j++) begin
         wr(uart_tx_abd_pkg::OFS_TX_CTRL,
            ctrl_val(1'b0, invert, 1'b0, 1'b1) & ~(8'(j == 2) << uart_tx_abd_pkg::B_HSPEED));
         wr(uart_tx_abd_pkg::OFS_BAUD_CTRL, (8'h01 << uart_tx_abd_pkg::B_ABD)
            | (8'(j == 0) << uart_tx_abd_pkg::B_WIDE)
            | (8'(j == 1) << uart_tx_abd_pkg::B_WAKE));
         // character written meanwhile must wait
         wr(uart_tx_abd_pkg::OFS_TX_DATA, 8'ha5);
         rd(uart_tx_abd_pkg::OFS_TX_CTRL);
         check(16'(rd_v[uart_tx_abd_pkg::B_EMPTY]), 16'h0001);
         wr(uart_tx_abd_pkg::OFS_TX_CTRL,
            ctrl_val(1'b0, invert, 1'b0, 1'b0) & ~(8'(j == 2) << uart_tx_abd_pkg::B_HSPEED));
         if (j == 1)
            i_node.send_break(SYNC_P);
         i_node.send_sync(SYNC_P);
         k = 0;
         rd_v = 8'h01;
         while (rd_v[uart_tx_abd_pkg::B_ABD] !== 1'b0 && k < 50) begin
            rd(uart_tx_abd_pkg::OFS_BAUD_CTRL);
            k++;
         end
         if (rd_v[uart_tx_abd_pkg::B_ABD] !== 1'b0)
            timed_out();
         rd(uart_tx_abd_pkg::OFS_INT_CTRL);
         check(16'(rd_v[uart_tx_abd_pkg::B_RXIF]), 16'h0001);
         rd(uart_tx_abd_pkg::OFS_DIV_LOW);
         lo = rd_v;
         rd(uart_tx_abd_pkg::OFS_DIV_HIGH);
         check({8'h00, rd_v}, 16'h0000);
         // one detect tick of phase slack at either edge
         ab = abd_expect(SYNC_P, 32 << (2 * j));
         check(16'(lo >= ab - 1 && lo <= ab + 1), 16'h0001);
         rd(uart_tx_abd_pkg::OFS_RX_DATA);
         rd(uart_tx_abd_pkg::OFS_INT_CTRL);
         check(16'(rd_v[uart_tx_abd_pkg::B_RXIF]), 16'h0000);
      end
      tally_and_finish();
   end
endmodule : test_uart_tx_abd
`default_nettype wire
